/* hdl/pcl_pkg.sv */
// constants for the synthesizer configuration and lock pin block
package pcl_pkg;

    // ****************************************
    // serial word layout
    // ****************************************
    localparam int WORD_W        = 32;
    localparam int ADDR_LSB      = 0;
    localparam int ADDR_W        = 4;
    localparam logic [3:0] ADDR_REF_MHZ = 4'hD;
    localparam logic [3:0] ADDR_REF_DIV = 4'hE;
    localparam logic [3:0] ADDR_FB_DIV  = 4'hF;

    // ****************************************
    // field positions
    // ****************************************
    localparam int REF_MHZ_LSB   = 14;
    localparam int REF_MHZ_W     = 8;
    localparam int REF_DIV_LSB   = 8;
    localparam int REF_DIV_W     = 12;
    localparam int PIN_SEL_LSB   = 20;
    localparam int PIN_SEL_W     = 4;
    localparam int SHUTDOWN_BIT  = 26;
    localparam int ALL_EN_BIT    = 27;
    localparam int DIRECT_EN_BIT = 28;
    localparam int FB_DIV_LSB    = 8;
    localparam int FB_DIV_W      = 18;
    localparam int POST_DIV_LSB  = 26;
    localparam int POST_DIV_W    = 4;
    localparam int GAIN_LSB      = 30;
    localparam int GAIN_W        = 2;

    // ****************************************
    // reset values and limits
    // ****************************************
    localparam logic [7:0]  RST_REF_MHZ   = 8'h0A;
    localparam logic [7:0]  MAX_REF_MHZ   = 8'hC8;
    localparam logic [11:0] RST_REF_DIV   = 12'h00A;
    localparam logic [3:0]  RST_PIN_SEL   = 4'h0;
    localparam logic        RST_SHUTDOWN  = 1'b0;
    localparam logic        RST_ALL_EN    = 1'b1;
    localparam logic        RST_DIRECT_EN = 1'b0;
    localparam logic [17:0] RST_FB_DIV    = 18'h002F8;
    localparam logic [3:0]  RST_POST_DIV  = 4'h2;
    localparam logic [3:0]  MIN_POST_DIV  = 4'h2;
    localparam logic [3:0]  MAX_POST_DIV  = 4'h8;
    localparam logic [1:0]  RST_GAIN      = 2'h0;

    // ****************************************
    // lock pin selector codes
    // ****************************************
    localparam logic [3:0] SEL_HIZ      = 4'h0;
    localparam logic [3:0] SEL_HIGH     = 4'h1;
    localparam logic [3:0] SEL_LOW      = 4'h2;
    localparam logic [3:0] SEL_DLOCK_H  = 4'h3;
    localparam logic [3:0] SEL_DLOCK_L  = 4'h4;
    localparam logic [3:0] SEL_ALOCK_PP = 4'h5;
    localparam logic [3:0] SEL_ALOCK_ON = 4'h6;
    localparam logic [3:0] SEL_ALOCK_OP = 4'h7;
    localparam logic [3:0] SEL_FB_HALF  = 4'h9;
    localparam logic [3:0] SEL_REF_HALF = 4'hB;

endpackage : pcl_pkg

/* hdl/pcl_divider.sv */
// binary tick divider with one-cycle output pulse and halved square wave
`timescale 1ns/10ps
module pcl_divider
    import pcl_pkg::*;
#(
    parameter int W = 12
) (
    input  wire logic         clk_sys,
    input  wire logic         rstn,
    input  wire logic         ce,
    input  wire logic         run,
    input  wire logic         tick,
    input  wire logic [W-1:0] div,
    output logic              pulse_q,
    output logic              half_q
);

    logic [W-1:0] count_q;
    logic         live;
    logic         last;

    assign live = run && (div != '0);
    assign last = (count_q == div - W'(1));

    // ****************************************
    // counter
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            count_q <= '0;
        end else if (ce) begin
            if (!live || count_q >= div) begin
                count_q <= '0;
            end else if (tick) begin
                count_q <= last ? '0 : count_q + W'(1);
            end
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            pulse_q <= 1'b0;
        end else if (ce) begin
            pulse_q <= live && tick && last;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            half_q <= 1'b0;
        end else if (ce) begin
            if (!live) begin
                half_q <= 1'b0;
            end else if (tick && last) begin
                half_q <= !half_q;
            end
        end
    end

endmodule : pcl_divider

/* hdl/pcl_config.sv */
// synthesizer configuration registers, dividers and lock status pin
`timescale 1ns/10ps
module pcl_config
    import pcl_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        ce,
    input  wire logic        cfg_clk,
    input  wire logic        cfg_data,
    input  wire logic        cfg_le,
    input  wire logic        reference_tick,
    input  wire logic        vco_tick,
    input  wire logic        dig_lock,
    input  wire logic        pump_active,
    input  wire logic        global_output_gate_pin,
    output logic             lock_status_pin_o,
    output logic             lock_status_pin_oe_n,
    output logic             ref_div_pulse,
    output logic             fb_div_pulse,
    output logic             cal_start,
    output logic             full_shutdown,
    output logic             all_outputs_on,
    output logic             direct_out_enable,
    output logic [1:0]       pump_gain_select,
    output logic [3:0]       post_div_value,
    output logic [7:0]       input_ref_mhz,
    output logic             ref_mhz_invalid,
    output logic             post_div_invalid
);

    // ****************************************
    // word address decode
    // ****************************************
    function automatic logic is_addr(input logic [WORD_W-1:0] w,
                                     input logic [3:0]        a);
        is_addr = (w[ADDR_LSB +: ADDR_W] == a);
    endfunction : is_addr

    // ****************************************
    // link domain shift register
    // ****************************************
    logic [WORD_W-1:0] shift_q;

    always_ff @(posedge cfg_clk) begin
        shift_q <= {shift_q[WORD_W-2:0], cfg_data};
    end

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [2:0] le_sync_q;
    logic       le_stable_q;
    logic       le_rise;
    logic [2:0] gate_sync_q;
    logic       gate_stable_q;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            le_sync_q <= 3'h0;
        end else if (ce) begin
            le_sync_q <= {le_sync_q[1:0], cfg_le};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            le_stable_q <= 1'b0;
        end else if (ce && le_sync_q[1] == le_sync_q[2]) begin
            le_stable_q <= le_sync_q[2];
        end
    end

    assign le_rise = ce && (le_sync_q[1] == le_sync_q[2])
                     && le_sync_q[2] && !le_stable_q;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            gate_sync_q <= 3'h0;
        end else if (ce) begin
            gate_sync_q <= {gate_sync_q[1:0], global_output_gate_pin};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            gate_stable_q <= 1'b0;
        end else if (ce && gate_sync_q[1] == gate_sync_q[2]) begin
            gate_stable_q <= gate_sync_q[2];
        end
    end

    // ****************************************
    // word capture
    // ****************************************
    logic [WORD_W-1:0] word;
    logic              wr_mhz;
    logic              wr_ref;
    logic              wr_fb;

    assign word   = shift_q;
    assign wr_mhz = le_rise && is_addr(word, ADDR_REF_MHZ);
    assign wr_ref = le_rise && is_addr(word, ADDR_REF_DIV);
    assign wr_fb  = le_rise && is_addr(word, ADDR_FB_DIV);

    // ****************************************
    // configuration registers
    // ****************************************
    logic [7:0]  ref_mhz_q;
    logic [11:0] ref_div_q;
    logic [3:0]  pin_sel_q;
    logic        shutdown_q;
    logic        all_en_q;
    logic        direct_en_q;
    logic [17:0] fb_div_q;
    logic [3:0]  post_div_q;
    logic [1:0]  gain_q;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ref_mhz_q <= RST_REF_MHZ;
        end else if (wr_mhz) begin
            ref_mhz_q <= word[REF_MHZ_LSB +: REF_MHZ_W];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ref_div_q   <= RST_REF_DIV;
            pin_sel_q   <= RST_PIN_SEL;
            shutdown_q  <= RST_SHUTDOWN;
            all_en_q    <= RST_ALL_EN;
            direct_en_q <= RST_DIRECT_EN;
        end else if (wr_ref) begin
            ref_div_q   <= word[REF_DIV_LSB +: REF_DIV_W];
            pin_sel_q   <= word[PIN_SEL_LSB +: PIN_SEL_W];
            shutdown_q  <= word[SHUTDOWN_BIT];
            all_en_q    <= word[ALL_EN_BIT];
            direct_en_q <= word[DIRECT_EN_BIT];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            fb_div_q   <= RST_FB_DIV;
            post_div_q <= RST_POST_DIV;
            gain_q     <= RST_GAIN;
        end else if (wr_fb) begin
            fb_div_q   <= word[FB_DIV_LSB +: FB_DIV_W];
            post_div_q <= word[POST_DIV_LSB +: POST_DIV_W];
            gain_q     <= word[GAIN_LSB +: GAIN_W];
        end
    end

    // ****************************************
    // calibration start
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cal_start <= 1'b0;
        end else if (ce) begin
            cal_start <= wr_fb && !shutdown_q;
        end
    end

    // ****************************************
    // divider chain
    // ****************************************
    logic post_ok;
    logic post_pulse;
    logic ref_half;
    logic fb_half;
    logic ref_pulse_w;
    logic fb_pulse_w;

    assign post_ok = (post_div_q >= MIN_POST_DIV)
                     && (post_div_q <= MAX_POST_DIV);

    pcl_divider #(.W(REF_DIV_W)) u_ref_div (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .ce      (ce),
        .run     (!shutdown_q),
        .tick    (reference_tick),
        .div     (ref_div_q),
        .pulse_q (ref_pulse_w),
        .half_q  (ref_half)
    );

    pcl_divider #(.W(POST_DIV_W)) u_post_div (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .ce      (ce),
        .run     (!shutdown_q && post_ok),
        .tick    (vco_tick),
        .div     (post_div_q),
        .pulse_q (post_pulse),
        .half_q  ()
    );

    pcl_divider #(.W(FB_DIV_W)) u_fb_div (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .ce      (ce),
        .run     (!shutdown_q),
        .tick    (post_pulse),
        .div     (fb_div_q),
        .pulse_q (fb_pulse_w),
        .half_q  (fb_half)
    );

    assign ref_div_pulse = ref_pulse_w;
    assign fb_div_pulse  = fb_pulse_w;

    // ****************************************
    // lock status pin
    // ****************************************
    logic pin_o_d;
    logic pin_oe_n_d;

    always_comb begin
        pin_o_d    = 1'b0;
        pin_oe_n_d = 1'b1;
        case (pin_sel_q)
            SEL_HIZ: begin
                pin_oe_n_d = 1'b1;
            end
            SEL_HIGH: begin
                pin_o_d    = 1'b1;
                pin_oe_n_d = 1'b0;
            end
            SEL_LOW: begin
                pin_o_d    = 1'b0;
                pin_oe_n_d = 1'b0;
            end
            SEL_DLOCK_H: begin
                pin_o_d    = dig_lock;
                pin_oe_n_d = 1'b0;
            end
            SEL_DLOCK_L: begin
                pin_o_d    = !dig_lock;
                pin_oe_n_d = 1'b0;
            end
            SEL_ALOCK_PP: begin
                pin_o_d    = !pump_active;
                pin_oe_n_d = 1'b0;
            end
            SEL_ALOCK_ON: begin
                pin_o_d    = 1'b0;
                pin_oe_n_d = !pump_active;
            end
            SEL_ALOCK_OP: begin
                pin_o_d    = 1'b1;
                pin_oe_n_d = pump_active;
            end
            SEL_FB_HALF: begin
                pin_o_d    = fb_half;
                pin_oe_n_d = 1'b0;
            end
            SEL_REF_HALF: begin
                pin_o_d    = ref_half;
                pin_oe_n_d = 1'b0;
            end
            default: begin
                pin_o_d    = 1'b0;
                pin_oe_n_d = 1'b1;
            end
        endcase
        if (shutdown_q) begin
            pin_o_d    = 1'b0;
            pin_oe_n_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            lock_status_pin_o    <= 1'b0;
            lock_status_pin_oe_n <= 1'b1;
        end else if (ce) begin
            lock_status_pin_o    <= pin_o_d;
            lock_status_pin_oe_n <= pin_oe_n_d;
        end
    end

    // ****************************************
    // enables and status
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            full_shutdown     <= 1'b0;
            all_outputs_on    <= 1'b0;
            direct_out_enable <= 1'b0;
        end else if (ce) begin
            full_shutdown     <= shutdown_q;
            all_outputs_on    <= !shutdown_q && all_en_q
                                 && gate_stable_q;
            direct_out_enable <= !shutdown_q && direct_en_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            pump_gain_select <= RST_GAIN;
            post_div_value   <= RST_POST_DIV;
            input_ref_mhz    <= RST_REF_MHZ;
            ref_mhz_invalid  <= 1'b0;
            post_div_invalid <= 1'b0;
        end else if (ce) begin
            pump_gain_select <= gain_q;
            post_div_value   <= post_div_q;
            input_ref_mhz    <= ref_mhz_q;
            ref_mhz_invalid  <= (ref_mhz_q == 8'h00)
                                || (ref_mhz_q > MAX_REF_MHZ);
            post_div_invalid <= !post_ok;
        end
    end

endmodule : pcl_config

/* tb/pcl_config_assertions.sv */
// concurrent checks on the configuration block ports
`timescale 1ns/10ps
module pcl_config_assertions
    import pcl_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       rstn,
    input wire logic       ce,
    input wire logic       reference_tick,
    input wire logic       vco_tick,
    input wire logic       global_output_gate_pin,
    input wire logic       lock_status_pin_oe_n,
    input wire logic       ref_div_pulse,
    input wire logic       fb_div_pulse,
    input wire logic       cal_start,
    input wire logic       full_shutdown,
    input wire logic       all_outputs_on,
    input wire logic       direct_out_enable,
    input wire logic [3:0] post_div_value,
    input wire logic [7:0] input_ref_mhz,
    input wire logic       ref_mhz_invalid,
    input wire logic       post_div_invalid
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    shut_pin_hiz_a: assert property (
        full_shutdown && $past(full_shutdown) |-> lock_status_pin_oe_n)
        else $error("pin driven in shutdown");
    shut_gates_a: assert property (
        full_shutdown |-> !all_outputs_on && !direct_out_enable)
        else $error("output enable set in shutdown");
    shut_no_pulse_a: assert property (
        full_shutdown && $past(full_shutdown) |-> !ref_div_pulse && !fb_div_pulse)
        else $error("divider pulse in shutdown");
    shut_no_cal_a: assert property (cal_start |-> !full_shutdown)
        else $error("calibration started in shutdown");
    cal_single_a: assert property (cal_start |=> !cal_start)
        else $error("calibration pulse too long");
    gate_low_off_a: assert property (
        (!global_output_gate_pin) [*6] |-> !all_outputs_on)
        else $error("outputs on with gate low");
    mhz_flag_a: assert property (
        ref_mhz_invalid == (input_ref_mhz == 8'h00 || input_ref_mhz > MAX_REF_MHZ))
        else $error("reference frequency flag wrong");
    post_flag_a: assert property (
        post_div_invalid == (post_div_value < MIN_POST_DIV || post_div_value > MAX_POST_DIV))
        else $error("post divider flag wrong");
    ref_cause_a: assert property (
        ref_div_pulse |-> $past(reference_tick) && $past(ce))
        else $error("reference pulse without tick");
    fb_cause_a: assert property (fb_div_pulse |-> $past(vco_tick, 2))
        else $error("feedback pulse without tick");
endmodule : pcl_config_assertions

bind pcl_config pcl_config_assertions pcl_config_assertions_i (
    .clk_sys, .rstn, .ce, .reference_tick, .vco_tick, .global_output_gate_pin,
    .lock_status_pin_oe_n, .ref_div_pulse, .fb_div_pulse, .cal_start, .full_shutdown,
    .all_outputs_on, .direct_out_enable, .post_div_value, .input_ref_mhz,
    .ref_mhz_invalid, .post_div_invalid
);

/* tb/pcl_host_model.sv */
// host controller model driving the serial configuration link
`timescale 1ns/10ps
module pcl_host_model
    import pcl_pkg::*;
(
    output logic cfg_clk,
    output logic cfg_data,
    output logic cfg_le
);
    // link clock stands low outside frames
    initial begin
        cfg_clk  = 1'b0;
        cfg_data = 1'b0;
        cfg_le   = 1'b0;
    end
    // one word msb first, then a latch pulse held for about ten system cycles
    task automatic send(input logic [WORD_W-1:0] w);
        for (int i = WORD_W - 1; i >= 0; i--) begin
            cfg_data = w[i];
            #32 cfg_clk = 1'b1;
            #32 cfg_clk = 1'b0;
        end
        #37 cfg_le = 1'b1;
        #203 cfg_le = 1'b0;
        cfg_data = ~cfg_data;
        #211;
    endtask : send
endmodule : pcl_host_model

/* tb/tb_pll_config_and_lock_pin_mux.sv */
// self-checking bench for the synthesizer configuration block
`timescale 1ns/10ps
module tb_pll_config_and_lock_pin_mux
    import pcl_pkg::*;
;
    logic clk_sys = 1'b0, rstn = 1'b0, ce = 1'b1, ref_t = 1'b0, vco_t = 1'b0;
    logic dl = 1'b0, pa = 1'b0, gate = 1'b1, cfg_clk, cfg_data, cfg_le;
    logic pin_o, oe_n, rp, fp, cal, sd, all_on, dir_en, mi, pi;
    logic [1:0] gain;
    logic [3:0] post;
    logic [7:0] mhz;
    logic [1:0] e;
    int n_fail = 0, n_checks = 0, n_ref = 0, n_fb = 0, n_cal = 0, c;
    logic [7:0] mt[4] = '{8'hC8, 8'hC9, 8'h01, 8'h00};

    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (rp === 1'b1) n_ref++;
        if (fp === 1'b1) n_fb++;
        if (cal === 1'b1) n_cal++;
    end

    pcl_host_model pcl_host_model_i (.cfg_clk(cfg_clk), .cfg_data(cfg_data), .cfg_le(cfg_le));
    pcl_config pcl_config_i (
        .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .cfg_clk(cfg_clk), .cfg_data(cfg_data),
        .cfg_le(cfg_le), .reference_tick(ref_t), .vco_tick(vco_t), .dig_lock(dl),
        .pump_active(pa), .global_output_gate_pin(gate), .lock_status_pin_o(pin_o),
        .lock_status_pin_oe_n(oe_n), .ref_div_pulse(rp), .fb_div_pulse(fp), .cal_start(cal),
        .full_shutdown(sd), .all_outputs_on(all_on), .direct_out_enable(dir_en),
        .pump_gain_select(gain), .post_div_value(post), .input_ref_mhz(mhz),
        .ref_mhz_invalid(mi), .post_div_invalid(pi)
    );

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic wr14(input logic [11:0] dv, input logic [3:0] s, input logic d, a, f);
        pcl_host_model_i.send({3'h0, f, a, d, 2'h0, s, dv, 4'h0, ADDR_REF_DIV});
    endtask : wr14
    task automatic wr15(input logic [17:0] n, input logic [3:0] p, input logic [1:0] g);
        pcl_host_model_i.send({g, p, n, 4'h0, ADDR_FB_DIV});
    endtask : wr15
    task automatic tick(input int n);
        @(posedge clk_sys);
        ref_t <= 1'b1;
        vco_t <= 1'b1;
        repeat (n) @(posedge clk_sys);
        ref_t <= 1'b0;
        vco_t <= 1'b0;
        repeat (4) @(negedge clk_sys);
    endtask : tick
    // returns output enable low and pin level
    function automatic logic [1:0] exp_pin(input logic [3:0] s, input logic p);
        case (s)
            SEL_HIGH: return 2'h1;
            SEL_LOW, SEL_FB_HALF, SEL_REF_HALF: return 2'h0;
            SEL_DLOCK_H: return {1'h0, p};
            SEL_DLOCK_L, SEL_ALOCK_PP: return {1'h0, ~p};
            SEL_ALOCK_ON: return {~p, 1'h0};
            SEL_ALOCK_OP: return {p, 1'h1};
            default: return 2'h2;
        endcase
    endfunction : exp_pin
    task automatic summarize;
        if (n_fail == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    initial begin
        #200000;
        n_fail++;
        summarize();
    end

    initial begin
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (8) @(negedge clk_sys);
        chk(8'(oe_n), 8'h01);
        chk(8'(gain), 8'h00);
        chk(8'(post), 8'h02);
        chk(mhz, 8'h0A);
        chk(8'(sd), 8'h00);
        chk(8'(all_on), 8'h01);
        chk(8'(dir_en), 8'h00);
        for (int i = 0; i < 4; i++) begin
            pcl_host_model_i.send({10'h0, mt[i], 10'h0, ADDR_REF_MHZ});
            chk(mhz, mt[i]);
            chk(8'(mi), 8'(i % 2));
        end
        for (int s = 0; s < 16; s++) begin
            wr14(12'h003, 4'(s), 1'b0, 1'b1, 1'b0);
            for (int p = 0; p < 2; p++) begin
                @(posedge clk_sys);
                dl <= 1'(p);
                pa <= 1'(p);
                repeat (3) @(negedge clk_sys);
                e = exp_pin(4'(s), 1'(p));
                chk(8'(oe_n), 8'(e[1]));
                if (!e[1] && s != 9 && s != 11) begin
                    chk(8'(pin_o), 8'(e[0]));
                end
            end
        end
        c = n_cal;
        wr15(18'h00003, 4'h2, 2'h0);
        chk(8'(n_cal - c), 8'h01);
        n_ref = 0;
        n_fb = 0;
        tick(60);
        chk(8'(n_ref), 8'h14);
        chk(8'(n_fb), 8'h0A);
        wr14(12'h003, SEL_REF_HALF, 1'b0, 1'b1, 1'b0);
        tick(3);
        chk(8'(pin_o), 8'h01);
        wr14(12'h003, SEL_FB_HALF, 1'b0, 1'b1, 1'b0);
        tick(5);
        chk(8'(pin_o), 8'h01);
        for (int g = 0; g < 4; g++) begin
            wr15(18'h00003, 4'h2, 2'(g));
            chk(8'(gain), 8'(g));
        end
        wr15(18'h00003, 4'h9, 2'h0);
        chk(8'(pi), 8'h01);
        n_fb = 0;
        tick(12);
        chk(8'(n_fb), 8'h00);
        wr15(18'h00001, 4'h8, 2'h0);
        chk(8'(pi), 8'h00);
        tick(16);
        chk(8'(n_fb), 8'h02);
        c = n_ref;
        @(posedge clk_sys);
        ce <= 1'b0;
        tick(6);
        chk(8'(n_ref - c), 8'h00);
        @(posedge clk_sys);
        ce <= 1'b1;
        wr14(12'h003, SEL_HIGH, 1'b1, 1'b1, 1'b1);
        chk({4'h0, sd, all_on, dir_en, oe_n}, 8'h09);
        c = n_cal;
        wr15(18'h00003, 4'h2, 2'h0);
        chk(8'(n_cal - c), 8'h00);
        wr14(12'h003, SEL_HIGH, 1'b0, 1'b0, 1'b1);
        chk({6'h00, all_on, dir_en}, 8'h01);
        wr14(12'h003, SEL_HIGH, 1'b0, 1'b1, 1'b1);
        chk(8'(all_on), 8'h01);
        @(posedge clk_sys);
        gate <= 1'b0;
        repeat (6) @(negedge clk_sys);
        chk(8'(all_on), 8'h00);
        @(posedge clk_sys);
        gate <= 1'b1;
        repeat (6) @(negedge clk_sys);
        chk(8'(all_on), 8'h01);
        summarize();
    end
endmodule : tb_pll_config_and_lock_pin_mux
